// ---- core/stop_clock_defs.svh ----
// Constants of the stop-clock throttle controller: field positions, encodings, times.
// Included by the controller; holds definitions only.
`ifndef STOP_CLOCK_DEFS_SVH
`define STOP_CLOCK_DEFS_SVH

// Ratio control words: [3:0] ratio code, [4] enable in the conserve and doze/sleep words
`define RATIO_CODE_MSB   3
`define RATIO_CODE_LSB   0
`define RATIO_EN_BIT     4
`define RATIO_CODE_MAX   4'h9
// Weight of a ratio in 5 % units; 100 % means no throttling
`define WEIGHT_FULL      5'h14

// Doze/sleep control: [10:8] release latency, [7:5] sleep option
`define SLEEP_OPT_MSB    7
`define SLEEP_OPT_LSB    5
`define LATENCY_MSB      10
`define LATENCY_LSB      8
`define OPT_NO_THROTTLE  3'h0
`define OPT_THROTTLE     3'h1
`define OPT_GRANT_HOLD   3'h2
`define OPT_CLOCK_HOLD   3'h3
`define OPT_DEEP_SLEEP   3'h4

// Throttle period = PERIOD_BASE bus periods shifted left by the period code
`define PERIOD_W         19
`define PERIOD_BASE      19'h00320
`define PERIOD_CODE_MAX  4'h9
`define RUN_PER_WEIGHT   19'h00028

// Overheat polarity field
`define OVERHEAT_POL_HIGH 2'h1
`define OVERHEAT_POL_LOW  2'h2

// Clock rate and times
`define CLK_MHZ          100
`define LAT_US_0         1
`define LAT_US_1         10
`define LAT_US_2         50
`define LAT_US_3         100
`define LAT_US_4         200
`define LAT_US_5         500
`define LAT_US_6         1000
`define LAT_US_7         2000
`define DEEP_WAKE_MS     20
`define IDLE_TICK_US     1000
`define WAIT_W           22

// Wake source codes
`define WAKE_NONE        3'h0
`define WAKE_SWITCH      3'h1
`define WAKE_RING        3'h2
`define WAKE_PIN0        3'h3
`define WAKE_PIN1        3'h4
`define WAKE_CLEAR       3'h7

`endif

// ---- core/stop_clock_pkg.sv ----
// Types shared by the stop-clock throttle controller and its bench.
// Plain package, no dependencies.
package stop_clock_pkg;

  typedef enum logic [1:0] {
    MODE_ON,
    MODE_DOZE,
    MODE_SLEEP,
    MODE_SUSPEND
  } pm_mode_e;

  typedef enum logic [3:0] {
    ST_RUN,
    ST_GRANT_HOLD,
    ST_CLK_WAIT,
    ST_CLK_STOPPED,
    ST_DEEP_WAIT,
    ST_DEEP_GATED,
    ST_DEEP_POWER,
    ST_LATENCY,
    ST_SUSPEND
  } hold_state_e;

endpackage

// ---- core/cpu_stop_clock_throttle_ctrl.sv ----
// Processor stop-clock request generator with throttling, sleep holds, deep sleep
// and suspend-to-memory wake handling. Assumes all inputs are synchronous to
// clk_sys_i and that mode timers and secondary-activity timers live outside.
//
// Behaviour
// - Throttle by toggling the stop-clock request, never touching processor clock rate.
// - Keep separate conserve, overheat and doze/sleep throttle ratios.
// - Period code picks 800 to 409600 bus periods; code 4 gives 12800.
// - Ratio is 5 % or 10..90 %, the share with request deasserted.
// - Overheat polarity is programmable; active overheat applies the overheat ratio.
// - When several ratios apply, the smallest run share wins.
// - Entering doze without overheat switches to the doze/sleep ratio.
// - Doze and sleep share one ratio; sleep may pick holds or deep sleep.
// - Sleep option 000 means no throttling in sleep.
// - Sleep option 001 throttles in sleep with the doze/sleep ratio.
// - Option 010 holds request asserted, clock running, until primary activity.
// - Option 011 holds request asserted, clock stopped, until primary activity.
// - After clock restart, wait the selected release latency before release.
// - Option 100 enters deep sleep.
// - In deep sleep any unmasked interrupt, serial line too, wakes the system.
// - Secondary activity never ends deep sleep.
// - Secondary activity overrides holds and overheat and doze/sleep throttling.
// - Without conserve, secondary activity releases at once; clock hold adds latency.
// - With conserve, secondary activity throttles at the conserve ratio.
// - Suspend only on software command; idle timer flags sleep time-out.
// - In suspend keep DRAM refreshed; wake on switch, ring, wake pin toggles.
// - Wake source field is read, then cleared by writing 111.
// - Entering suspend resets the listed register groups, keeping DRAM control.
// - Deep sleep: assert request, await stop grant, stop clock, gate input clock.
// - Deep wake: power on clocks, wait 20 ms, ungate, restart, latency, release.
// - Primary activity from doze returns to on, which means conserve if enabled.
// - Secondary activity in sleep revives the system until it ends.
`timescale 1ns/100ps
`include "stop_clock_defs.svh"

module cpu_stop_clock_throttle_ctrl #(
  parameter int unsigned DEEP_WAKE_CYCLES   = `DEEP_WAKE_MS * 1000 * `CLK_MHZ,
  parameter int unsigned LAT_CYCLES_PER_US  = `CLK_MHZ,
  parameter int unsigned IDLE_TICK_CYCLES   = `IDLE_TICK_US * `CLK_MHZ
) (
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_i,
  input  wire logic [3:0]               throttle_period_ctrl_i,
  input  wire logic [4:0]               conserve_ratio_ctrl_i,
  input  wire logic [4:0]               overheat_ratio_ctrl_i,
  input  wire logic [10:0]              doze_sleep_ratio_ctrl_i,
  input  wire logic [1:0]               overheat_polarity_i,
  input  wire logic                     overheat_input_i,
  input  wire stop_clock_pkg::pm_mode_e mode_req_i,
  input  wire logic                     mode_req_valid_i,
  input  wire logic                     suspend_cmd_i,
  input  wire logic [7:0]               suspend_idle_timer_i,
  input  wire logic                     primary_activity_i,
  input  wire logic                     irq_request_i,
  input  wire logic                     serial_irq_line_i,
  input  wire logic                     secondary_activity_i,
  input  wire logic                     stop_grant_i,
  input  wire logic                     switch_input_i,
  input  wire logic                     ring_input_i,
  input  wire logic                     wake_pin_zero_i,
  input  wire logic                     wake_pin_one_i,
  input  wire logic                     wake_src_wr_i,
  input  wire logic [2:0]               wake_src_wdata_i,
  output logic                          cpu_stop_clock_request_n_o,
  output logic                          processor_clock_run_o,
  output logic                          input_clock_pass_o,
  output logic                          power_ctrl_o,
  output stop_clock_pkg::pm_mode_e      pm_mode_o,
  output logic [2:0]                    wake_src_o,
  output logic                          suspend_timeout_o,
  output logic                          dram_refresh_keep_o,
  output logic                          suspend_reg_reset_o
);

  stop_clock_pkg::pm_mode_e    mode_r;
  stop_clock_pkg::pm_mode_e    mode_nxt;
  stop_clock_pkg::hold_state_e state_r;
  stop_clock_pkg::hold_state_e state_nxt;
  logic [`WAIT_W-1:0]          wait_cnt_r;
  logic [`WAIT_W-1:0]          wait_cnt_nxt;
  logic [`PERIOD_W-1:0]        cnt_r;
  logic [`PERIOD_W-1:0]        period_r;
  logic [`PERIOD_W-1:0]        run_r;
  logic [`PERIOD_W-1:0]        period_nxt;
  logic [`PERIOD_W-1:0]        run_nxt;
  logic                        thr_en_r;
  logic                        serial_prev_r;
  logic                        switch_prev_r;
  logic                        ring_prev_r;
  logic                        wake_pin_zero_prev_r;
  logic                        wake_pin_one_prev_r;
  logic [31:0]                 tick_cnt_r;
  logic [7:0]                  idle_cnt_r;
  logic                        primary_act;
  logic                        in_sleep;
  logic [2:0]                  sleep_opt;
  logic                        overheat_active;
  logic                        con_app;
  logic                        heat_app;
  logic                        ds_app;
  logic                        throttle_any;
  logic [4:0]                  weight_min;
  logic                        period_end;
  logic                        throttle_req;
  logic [2:0]                  wake_set;
  logic [`WAIT_W-1:0]          latency_cycles;

  // Weight of a ratio code in 5 % steps; codes above the top step clamp to 90 %
  function automatic logic [4:0] ratio_weight(input logic [3:0] code);
    logic [3:0] c;
    c = (code > `RATIO_CODE_MAX) ? `RATIO_CODE_MAX : code;
    ratio_weight = (c == 4'h0) ? 5'h01 : {c, 1'b0};
  endfunction

  function automatic logic [`WAIT_W-1:0] lat_cycles(input logic [2:0] code);
    int unsigned us;
    case (code)
      3'h0:    us = `LAT_US_0;
      3'h1:    us = `LAT_US_1;
      3'h2:    us = `LAT_US_2;
      3'h3:    us = `LAT_US_3;
      3'h4:    us = `LAT_US_4;
      3'h5:    us = `LAT_US_5;
      3'h6:    us = `LAT_US_6;
      default: us = `LAT_US_7;
    endcase
    lat_cycles = `WAIT_W'(us * LAT_CYCLES_PER_US);
  endfunction

  // Interrupts, including a change on the serial interrupt line, count as primary
  assign primary_act = primary_activity_i | irq_request_i |
                       (serial_irq_line_i ^ serial_prev_r);
  assign in_sleep    = (mode_r == stop_clock_pkg::MODE_SLEEP);
  assign sleep_opt   = doze_sleep_ratio_ctrl_i[`SLEEP_OPT_MSB:`SLEEP_OPT_LSB];
  assign latency_cycles = lat_cycles(doze_sleep_ratio_ctrl_i[`LATENCY_MSB:`LATENCY_LSB]);

  always_comb begin
    case (overheat_polarity_i)
      `OVERHEAT_POL_HIGH: overheat_active = overheat_input_i;
      `OVERHEAT_POL_LOW:  overheat_active = ~overheat_input_i;
      default:            overheat_active = 1'b0;
    endcase
  end

  // Which ratios apply now; secondary activity leaves only the conserve ratio
  always_comb begin
    con_app  = conserve_ratio_ctrl_i[`RATIO_EN_BIT] &&
               (mode_r != stop_clock_pkg::MODE_SUSPEND);
    heat_app = overheat_active && !secondary_activity_i &&
               (mode_r != stop_clock_pkg::MODE_SUSPEND);
    ds_app   = doze_sleep_ratio_ctrl_i[`RATIO_EN_BIT] && !secondary_activity_i &&
               ((mode_r == stop_clock_pkg::MODE_DOZE) ||
                (in_sleep && sleep_opt == `OPT_THROTTLE));
    throttle_any = con_app | heat_app | ds_app;
    weight_min = `WEIGHT_FULL;
    if (con_app && ratio_weight(conserve_ratio_ctrl_i[3:0]) < weight_min) begin
      weight_min = ratio_weight(conserve_ratio_ctrl_i[3:0]);
    end
    if (heat_app && ratio_weight(overheat_ratio_ctrl_i[3:0]) < weight_min) begin
      weight_min = ratio_weight(overheat_ratio_ctrl_i[3:0]);
    end
    if (ds_app && ratio_weight(doze_sleep_ratio_ctrl_i[3:0]) < weight_min) begin
      weight_min = ratio_weight(doze_sleep_ratio_ctrl_i[3:0]);
    end
  end

  // Exact: 5 % of 800 periods is 40, and the period doubles per code step
  always_comb begin
    logic [3:0] pcode;
    pcode = (throttle_period_ctrl_i > `PERIOD_CODE_MAX) ? `PERIOD_CODE_MAX
                                                        : throttle_period_ctrl_i;
    period_nxt = `PERIOD_BASE << pcode;
    run_nxt    = (`PERIOD_W'(weight_min) * `RUN_PER_WEIGHT) << pcode;
  end

  assign period_end = (cnt_r >= period_r - `PERIOD_W'(1));

  // Period and ratio are sampled only at a boundary so no period is cut short
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r    <= '0;
      period_r <= `PERIOD_BASE;
      run_r    <= `PERIOD_BASE;
      thr_en_r <= 1'b0;
    end else if (period_end) begin
      cnt_r    <= '0;
      period_r <= period_nxt;
      run_r    <= run_nxt;
      thr_en_r <= throttle_any;
    end else begin
      cnt_r <= cnt_r + `PERIOD_W'(1);
    end
  end

  // Release is immediate once nothing applies; processor clock is never touched here
  assign throttle_req = thr_en_r && throttle_any && (cnt_r >= run_r);

  // Mode tracking
  always_comb begin
    mode_nxt = mode_r;
    if (mode_r == stop_clock_pkg::MODE_SUSPEND) begin
      if (wake_set != `WAKE_NONE) begin
        mode_nxt = stop_clock_pkg::MODE_ON;
      end
    end else if (suspend_cmd_i) begin
      mode_nxt = stop_clock_pkg::MODE_SUSPEND;
    end else if (primary_act) begin
      mode_nxt = stop_clock_pkg::MODE_ON;
    end else if (mode_req_valid_i && mode_req_i != stop_clock_pkg::MODE_SUSPEND) begin
      mode_nxt = mode_req_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r              <= stop_clock_pkg::MODE_ON;
      suspend_reg_reset_o <= 1'b0;
      dram_refresh_keep_o <= 1'b0;
    end else begin
      mode_r              <= mode_nxt;
      suspend_reg_reset_o <= (mode_nxt == stop_clock_pkg::MODE_SUSPEND) &&
                             (mode_r != stop_clock_pkg::MODE_SUSPEND);
      dram_refresh_keep_o <= (mode_nxt == stop_clock_pkg::MODE_SUSPEND);
    end
  end

  // Hold sequencer for the sleep options, deep sleep and suspend
  always_comb begin
    state_nxt    = state_r;
    wait_cnt_nxt = wait_cnt_r;
    case (state_r)
      stop_clock_pkg::ST_RUN: begin
        if (mode_r == stop_clock_pkg::MODE_SUSPEND) begin
          state_nxt = stop_clock_pkg::ST_SUSPEND;
        end else if (in_sleep && !secondary_activity_i && !primary_act) begin
          case (sleep_opt)
            `OPT_GRANT_HOLD: state_nxt = stop_clock_pkg::ST_GRANT_HOLD;
            `OPT_CLOCK_HOLD: state_nxt = stop_clock_pkg::ST_CLK_WAIT;
            `OPT_DEEP_SLEEP: state_nxt = stop_clock_pkg::ST_DEEP_WAIT;
            default:         state_nxt = stop_clock_pkg::ST_RUN;
          endcase
        end
      end
      stop_clock_pkg::ST_GRANT_HOLD: begin
        if (!in_sleep || secondary_activity_i) begin
          state_nxt = stop_clock_pkg::ST_RUN;
        end
      end
      stop_clock_pkg::ST_CLK_WAIT: begin
        if (!in_sleep || secondary_activity_i) begin
          state_nxt = stop_clock_pkg::ST_RUN;
        end else if (stop_grant_i) begin
          state_nxt = stop_clock_pkg::ST_CLK_STOPPED;
        end
      end
      stop_clock_pkg::ST_CLK_STOPPED: begin
        if (!in_sleep || secondary_activity_i) begin
          state_nxt    = stop_clock_pkg::ST_LATENCY;
          wait_cnt_nxt = latency_cycles;
        end
      end
      stop_clock_pkg::ST_DEEP_WAIT: begin
        // Secondary activity is ignored from here on to keep the power saving
        if (!in_sleep) begin
          state_nxt = stop_clock_pkg::ST_RUN;
        end else if (stop_grant_i) begin
          state_nxt = stop_clock_pkg::ST_DEEP_GATED;
        end
      end
      stop_clock_pkg::ST_DEEP_GATED: begin
        if (!in_sleep) begin
          state_nxt    = stop_clock_pkg::ST_DEEP_POWER;
          wait_cnt_nxt = `WAIT_W'(DEEP_WAKE_CYCLES);
        end
      end
      stop_clock_pkg::ST_DEEP_POWER: begin
        if (wait_cnt_r <= `WAIT_W'(1)) begin
          state_nxt    = stop_clock_pkg::ST_LATENCY;
          wait_cnt_nxt = latency_cycles;
        end else begin
          wait_cnt_nxt = wait_cnt_r - `WAIT_W'(1);
        end
      end
      stop_clock_pkg::ST_LATENCY: begin
        if (wait_cnt_r <= `WAIT_W'(1)) begin
          state_nxt = stop_clock_pkg::ST_RUN;
        end else begin
          wait_cnt_nxt = wait_cnt_r - `WAIT_W'(1);
        end
      end
      stop_clock_pkg::ST_SUSPEND: begin
        if (mode_r != stop_clock_pkg::MODE_SUSPEND) begin
          state_nxt    = stop_clock_pkg::ST_LATENCY;
          wait_cnt_nxt = latency_cycles;
        end
      end
      default: begin
        state_nxt = stop_clock_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_r    <= stop_clock_pkg::ST_RUN;
      wait_cnt_r <= '0;
    end else begin
      state_r    <= state_nxt;
      wait_cnt_r <= wait_cnt_nxt;
    end
  end

  // Outputs follow the next state so they line up with state_r
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_stop_clock_request_n_o <= 1'b1;
      processor_clock_run_o      <= 1'b1;
      input_clock_pass_o         <= 1'b1;
      power_ctrl_o               <= 1'b1;
    end else begin
      cpu_stop_clock_request_n_o <= !((state_nxt != stop_clock_pkg::ST_RUN) ||
                                      throttle_req);
      processor_clock_run_o      <= !((state_nxt == stop_clock_pkg::ST_CLK_STOPPED) ||
                                      (state_nxt == stop_clock_pkg::ST_DEEP_GATED) ||
                                      (state_nxt == stop_clock_pkg::ST_DEEP_POWER) ||
                                      (state_nxt == stop_clock_pkg::ST_SUSPEND));
      input_clock_pass_o         <= !((state_nxt == stop_clock_pkg::ST_DEEP_GATED) ||
                                      (state_nxt == stop_clock_pkg::ST_DEEP_POWER));
      power_ctrl_o               <= (state_nxt != stop_clock_pkg::ST_DEEP_GATED);
    end
  end

  // Input history for toggle detection
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      serial_prev_r <= 1'b0;
      switch_prev_r <= 1'b0;
      ring_prev_r   <= 1'b0;
      wake_pin_zero_prev_r  <= 1'b0;
      wake_pin_one_prev_r  <= 1'b0;
    end else begin
      serial_prev_r <= serial_irq_line_i;
      switch_prev_r <= switch_input_i;
      ring_prev_r   <= ring_input_i;
      wake_pin_zero_prev_r  <= wake_pin_zero_i;
      wake_pin_one_prev_r  <= wake_pin_one_i;
    end
  end

  // Toggles only wake from suspend; first pin in this order names the source
  always_comb begin
    wake_set = `WAKE_NONE;
    if (mode_r == stop_clock_pkg::MODE_SUSPEND) begin
      if (switch_input_i ^ switch_prev_r) begin
        wake_set = `WAKE_SWITCH;
      end else if (ring_input_i ^ ring_prev_r) begin
        wake_set = `WAKE_RING;
      end else if (wake_pin_zero_i ^ wake_pin_zero_prev_r) begin
        wake_set = `WAKE_PIN0;
      end else if (wake_pin_one_i ^ wake_pin_one_prev_r) begin
        wake_set = `WAKE_PIN1;
      end
    end
  end

  // A wake in the same cycle as the clear write is kept
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wake_src_o <= `WAKE_NONE;
    end else if (wake_set != `WAKE_NONE) begin
      wake_src_o <= wake_set;
    end else if (wake_src_wr_i && wake_src_wdata_i == `WAKE_CLEAR) begin
      wake_src_o <= `WAKE_NONE;
    end
  end

  // Sleep idle time in ticks; flags the time-out, suspend itself waits for software
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_r        <= '0;
      idle_cnt_r        <= '0;
      suspend_timeout_o <= 1'b0;
    end else if (!in_sleep || primary_act) begin
      tick_cnt_r        <= '0;
      idle_cnt_r        <= '0;
      suspend_timeout_o <= 1'b0;
    end else if (tick_cnt_r >= IDLE_TICK_CYCLES - 1) begin
      tick_cnt_r        <= '0;
      suspend_timeout_o <= (suspend_idle_timer_i != 8'h00) &&
                           (idle_cnt_r + 8'h01 == suspend_idle_timer_i);
      if (idle_cnt_r != 8'hFF) begin
        idle_cnt_r <= idle_cnt_r + 8'h01;
      end
    end else begin
      tick_cnt_r        <= tick_cnt_r + 32'h1;
      suspend_timeout_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pm_mode_o <= stop_clock_pkg::MODE_ON;
    end else begin
      pm_mode_o <= mode_nxt;
    end
  end

endmodule

// ---- dv/cpu_stop_clock_throttle_ctrl_chk.sv ----
// Port-level assertions for the stop-clock controller.
// Bound to every controller instance; one clock domain, async reset.
`timescale 1ns/100ps
module cpu_stop_clock_chk (
  input wire logic                     clk_sys_i,
  input wire logic                     rst_i,
  input wire logic                     suspend_cmd_i,
  input wire logic                     mode_req_valid_i,
  input wire logic                     primary_activity_i,
  input wire logic                     irq_request_i,
  input wire logic                     serial_irq_line_i,
  input wire logic                     wake_src_wr_i,
  input wire logic [2:0]               wake_src_wdata_i,
  input wire logic                     cpu_stop_clock_request_n_o,
  input wire logic                     processor_clock_run_o,
  input wire logic                     input_clock_pass_o,
  input wire logic                     power_ctrl_o,
  input wire stop_clock_pkg::pm_mode_e pm_mode_o,
  input wire logic [2:0]               wake_src_o,
  input wire logic                     dram_refresh_keep_o,
  input wire logic                     suspend_reg_reset_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Gated and nothing that counts as primary activity
  sequence s_quiet;
    !power_ctrl_o && !primary_activity_i && !irq_request_i && $stable(serial_irq_line_i) &&
    !mode_req_valid_i && !suspend_cmd_i;
  endsequence
  a_susp_by_cmd: assert property (
    pm_mode_o != stop_clock_pkg::MODE_SUSPEND && !suspend_cmd_i
    |=> pm_mode_o != stop_clock_pkg::MODE_SUSPEND) else $error("suspend without command");
  a_susp_refresh: assert property (
    pm_mode_o == stop_clock_pkg::MODE_SUSPEND |-> dram_refresh_keep_o)
    else $error("refresh not kept");
  a_susp_reg_reset: assert property (
    $rose(pm_mode_o == stop_clock_pkg::MODE_SUSPEND) |-> suspend_reg_reset_o
    ##1 !suspend_reg_reset_o) else $error("register reset pulse wrong");
  a_wake_clear: assert property (
    wake_src_wr_i && wake_src_wdata_i == 3'h7 && pm_mode_o != stop_clock_pkg::MODE_SUSPEND
    |=> wake_src_o == 3'h0) else $error("wake source not cleared");
  a_deep_no_revive: assert property (s_quiet ##1 s_quiet |=> !power_ctrl_o)
    else $error("deep sleep left without primary");
  a_deep_wake: assert property (
    !power_ctrl_o && primary_activity_i |-> ##[1:3] power_ctrl_o) else $error("no deep wake");
  a_gate_order: assert property (
    $fell(input_clock_pass_o) |-> !processor_clock_run_o && !cpu_stop_clock_request_n_o)
    else $error("input clock gated too early");
  a_clock_stop: assert property (
    $fell(processor_clock_run_o) |-> !cpu_stop_clock_request_n_o)
    else $error("clock stopped without request");
  a_release_run: assert property (
    $rose(cpu_stop_clock_request_n_o) |-> processor_clock_run_o && input_clock_pass_o)
    else $error("request released with clock stopped");
endmodule
bind cpu_stop_clock_throttle_ctrl cpu_stop_clock_chk cpu_stop_clock_chk_i (.*);

// ---- dv/cpu_bus_proc_model.sv ----
// Processor on the bus: answers a held stop-clock request with one stop-grant cycle.
// Same clock as the controller; GRANT_DLY sets prompt or slow answers.
`timescale 1ns/100ps
module cpu_bus_proc_model #(
  parameter int GRANT_DLY = 3
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic stop_n_i,
  output logic      grant_o
);
  int cnt_r;
  // One grant per assertion; a released request restarts the wait
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i || stop_n_i) begin
      cnt_r   <= 0;
      grant_o <= 1'h0;
    end else begin
      grant_o <= (cnt_r == GRANT_DLY);
      if (cnt_r <= GRANT_DLY) cnt_r <= cnt_r + 1;
    end
  end
endmodule

// ---- dv/cpu_stop_clock_throttle_ctrl_tb.sv ----
// Self-checking bench for the stop-clock controller with a processor model.
// Long waits are shortened through the controller's parameters.
`timescale 1ns/100ps
module cpu_stop_clock_throttle_ctrl_tb;
  logic        clk_sys_i = 1'h0;
  logic        rst_i = 1'h1;
  logic [3:0]  wk = 4'h0;
  logic [1:0]  pol = 2'h1;
  logic [7:0]  idle = 8'h02;
  logic [4:0]  con = 5'h00, hot = 5'h00;
  logic [10:0] ds = 11'h000;
  logic        hot_in = 1'h0, mv = 1'h0, scmd = 1'h0, pa = 1'h0, sa = 1'h0, wr = 1'h0, ser = 1'h0;
  logic [2:0]  wd = 3'h0, src;
  logic        stop_n, run, pass, pwr, keep, rr, grant, sto;
  stop_clock_pkg::pm_mode_e mr = stop_clock_pkg::MODE_ON, mode;
  int          n_mismatch = 0, checks_done = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  cpu_stop_clock_throttle_ctrl #(.DEEP_WAKE_CYCLES(50), .LAT_CYCLES_PER_US(1),
    .IDLE_TICK_CYCLES(10)) cpu_stop_clock_throttle_ctrl_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .throttle_period_ctrl_i(4'h0),
    .conserve_ratio_ctrl_i(con), .overheat_ratio_ctrl_i(hot), .doze_sleep_ratio_ctrl_i(ds),
    .overheat_polarity_i(pol), .overheat_input_i(hot_in), .mode_req_i(mr),
    .mode_req_valid_i(mv), .suspend_cmd_i(scmd), .suspend_idle_timer_i(idle),
    .primary_activity_i(pa), .irq_request_i(1'h0), .serial_irq_line_i(ser),
    .secondary_activity_i(sa), .stop_grant_i(grant), .switch_input_i(wk[0]),
    .ring_input_i(wk[1]), .wake_pin_zero_i(wk[2]), .wake_pin_one_i(wk[3]),
    .wake_src_wr_i(wr), .wake_src_wdata_i(wd), .cpu_stop_clock_request_n_o(stop_n),
    .processor_clock_run_o(run), .input_clock_pass_o(pass), .power_ctrl_o(pwr),
    .pm_mode_o(mode), .wake_src_o(src), .suspend_timeout_o(sto), .dram_refresh_keep_o(keep),
    .suspend_reg_reset_o(rr));
  cpu_bus_proc_model cpu_bus_proc_model_i (.clk_i(clk_sys_i), .rst_i(rst_i),
    .stop_n_i(stop_n), .grant_o(grant));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // One full period of 800 cycles sees every phase once, whatever the start
  task automatic lows(output int k);
    k = 0;
    repeat (800) begin
      cyc(1);
      if (stop_n === 1'h0) k++;
    end
  endtask
  task automatic set_mode(input stop_clock_pkg::pm_mode_e m);
    @(posedge clk_sys_i) begin mr <= m; mv <= 1'h1; end
    @(posedge clk_sys_i) mv <= 1'h0;
  endtask
  task automatic pulse_pa();
    @(posedge clk_sys_i) pa <= 1'h1;
    @(posedge clk_sys_i) pa <= 1'h0;
  endtask
  task automatic wr_src(input logic [2:0] d);
    @(posedge clk_sys_i) begin wr <= 1'h1; wd <= d; end
    @(posedge clk_sys_i) wr <= 1'h0;
    cyc(1);
  endtask
  task automatic t_ratio(input logic [4:0] c, h, input logic hi, input int exp);
    int k;
    @(posedge clk_sys_i) begin con <= c; hot <= h; hot_in <= hi; end
    cyc(1700);
    lows(k);
    chk("low_cycles", exp, k);
    chk("cpu_clk_run", 1, run);
    $display("ratio test %0h/%0h done", c, h);
  endtask
  task automatic t_doze();
    int k;
    @(posedge clk_sys_i) begin con <= 5'h00; hot_in <= 1'h0; ds <= 11'h012; pol <= 2'h1; end
    set_mode(stop_clock_pkg::MODE_DOZE);
    cyc(1700);
    lows(k);
    chk("doze_low", 640, k);
    @(posedge clk_sys_i) sa <= 1'h1;
    cyc(3);
    lows(k);
    chk("sec_low", 0, k);
    @(posedge clk_sys_i) con <= 5'h15;
    cyc(1700);
    lows(k);
    chk("sec_con_low", 400, k);
    @(posedge clk_sys_i) sa <= 1'h0;
    pulse_pa();
    cyc(2);
    chk("doze_exit", stop_clock_pkg::MODE_ON, mode);
    @(posedge clk_sys_i) con <= 5'h00;
    $display("doze test done");
  endtask
  task automatic t_hold(input logic [10:0] d, input logic r, p);
    int k;
    @(posedge clk_sys_i) ds <= d;
    set_mode(stop_clock_pkg::MODE_SLEEP);
    repeat (30) begin
      cyc(1);
      if (sto === 1'h1) k++;
    end
    chk("idle_timeout", 1, k);
    lows(k);
    chk("hold_low", 800, k);
    chk("cpu_clk_run", r, run);
    chk("power", p, pwr);
    @(posedge clk_sys_i) sa <= 1'h1;
    cyc(10);
    chk("sec_release", p, stop_n);
    @(posedge clk_sys_i) sa <= 1'h0;
    cyc(30);
    if (r ^ p) @(posedge clk_sys_i) ser <= ~ser;
    else pulse_pa();
    cyc(80);
    chk("pa_release", 1, stop_n);
    chk("pa_mode", stop_clock_pkg::MODE_ON, mode);
    $display("hold test %0h done", d);
  endtask
  task automatic t_susp();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i) scmd <= 1'h1;
      @(posedge clk_sys_i) scmd <= 1'h0;
      #1;
      chk("reg_reset", 1, rr);
      chk("refresh", 1, keep);
      @(posedge clk_sys_i) wk[i] <= ~wk[i];
      cyc(2);
      chk("wake_src", i + 1, src);
      chk("wake_mode", stop_clock_pkg::MODE_ON, mode);
      wr_src(3'h3);
      chk("src_kept", i + 1, src);
      wr_src(3'h7);
      chk("src_clear", 0, src);
    end
    $display("suspend test done");
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #800000;
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    cyc(1);
    chk("rst_stop_n", 1, stop_n);
    chk("rst_power", 1, pwr);
    chk("rst_mode", stop_clock_pkg::MODE_ON, mode);
    t_ratio(5'h15, 5'h00, 1'h0, 400);
    t_ratio(5'h10, 5'h00, 1'h0, 760);
    t_ratio(5'h15, 5'h02, 1'h1, 640);
    t_ratio(5'h12, 5'h05, 1'h1, 640);
    @(posedge clk_sys_i) pol <= 2'h2;
    t_ratio(5'h15, 5'h02, 1'h0, 640);
    t_doze();
    t_hold(11'h040, 1'h1, 1'h1);
    t_hold(11'h060, 1'h0, 1'h1);
    t_hold(11'h080, 1'h0, 1'h0);
    t_susp();
    conclude();
  end
endmodule
